/* File: core/nvm_prog_port.sv */
// parallel programming port: command, address and data latches, fuses, locks, readback
`timescale 1ns/1ns
`default_nettype none
`include "nvm_prog_consts.svh"
module nvm_prog_port
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire nvm_prog_pkg::prog_ctrl_s ctrl,
    input wire logic [7:0] prog_data_bus_in,
    output logic [7:0] prog_data_bus_out,
    output logic prog_data_bus_oe,
    output logic ready_busy_n,
    output logic [11:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_write,
    output logic mem_erase,
    output logic serial_prog_enable_fuse,
    output logic fast_start_fuse,
    output logic lock_bit1,
    output logic lock_bit2,
    output logic [7:0] command
);
    // ------------------------------------------------------------
    // signature values (arbitrary, not identifying any maker)
    // ------------------------------------------------------------
    localparam logic [7:0] SIG_BYTE0 = 8'h5A;
    localparam logic [7:0] SIG_BYTE1 = 8'h11;
    localparam logic [7:0] SIG_BYTE2 = 8'h22;

    // ------------------------------------------------------------
    // strobe edge detection
    // ------------------------------------------------------------
    logic load_strobe_q;
    logic write_strobe_q;
    logic load_pulse;
    logic write_pulse;
    nvm_prog_pkg::prog_addr_s addr;
    logic [7:0] data_lo;
    nvm_prog_pkg::prog_state_e state;
    logic [15:0] timer_cycles;
    logic timer_start;
    logic timer_done;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            load_strobe_q <= 1'b0;
            write_strobe_q <= 1'b1;
        end
        else
        begin
            load_strobe_q <= ctrl.load_strobe;
            write_strobe_q <= ctrl.write_strobe_n;
        end
    end

    // inputs are synchronous, so edges are taken on the rising load and falling write strobe
    assign load_pulse = ctrl.load_strobe && !load_strobe_q;
    assign write_pulse = !ctrl.write_strobe_n && write_strobe_q;

    function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] v);
        is_cmd = (c == v);
    endfunction

    // ------------------------------------------------------------
    // command, address and data latches
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            command <= 8'h00;
        end
        else if (load_pulse && ctrl.action == `ACT_CMD)
        begin
            command <= prog_data_bus_in; // see RL2 see RL20
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr <= '0;
        end
        else if (load_pulse && ctrl.action == `ACT_ADDR)
        begin
            if (ctrl.byte_select)
            begin
                // upper bits beyond the flash range are dropped
                addr.hi <= prog_data_bus_in[3:0]; // see RL4 see RL20
            end
            else
            begin
                addr.lo <= prog_data_bus_in; // see RL5 see RL20
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_lo <= 8'hFF;
        end
        else if (load_pulse && ctrl.action == `ACT_DATA && !ctrl.byte_select)
        begin
            data_lo <= prog_data_bus_in; // see RL6 see RL20
        end
    end

    // ------------------------------------------------------------
    // operation sequencing
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= nvm_prog_pkg::ST_IDLE;
        end
        else
        begin
            case (state)
                nvm_prog_pkg::ST_IDLE:
                begin
                    if (write_pulse && !ctrl.byte_select && is_cmd(command, `CMD_WRITE_FLASH))
                    begin
                        state <= nvm_prog_pkg::ST_FLASH; // see RL3 see RL7
                    end
                    else if (write_pulse && is_cmd(command, `CMD_CHIP_ERASE))
                    begin
                        state <= nvm_prog_pkg::ST_ERASE_MEM; // see RL19
                    end
                end
                nvm_prog_pkg::ST_FLASH:
                begin
                    if (timer_done)
                    begin
                        state <= nvm_prog_pkg::ST_IDLE; // see RL21
                    end
                end
                nvm_prog_pkg::ST_ERASE_MEM:
                begin
                    // locks stay set until both memories are fully erased
                    if (timer_done)
                    begin
                        state <= nvm_prog_pkg::ST_ERASE_LOCK; // see RL19
                    end
                end
                nvm_prog_pkg::ST_ERASE_LOCK:
                begin
                    state <= nvm_prog_pkg::ST_IDLE;
                end
                default:
                begin
                    state <= nvm_prog_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign timer_start = (state == nvm_prog_pkg::ST_IDLE) && write_pulse &&
        ((!ctrl.byte_select && is_cmd(command, `CMD_WRITE_FLASH)) || is_cmd(command, `CMD_CHIP_ERASE));
    assign timer_cycles = is_cmd(command, `CMD_CHIP_ERASE) ? 16'(`ERASE_STEP_CYCLES) : 16'(`FLASH_WRITE_CYCLES);

    nvm_prog_timer u_timer
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .start(timer_start),
        .cycles(timer_cycles),
        .done(timer_done)
    );

    // fuse writes and erase leave ready high; only flash writes show busy
    assign ready_busy_n = (state != nvm_prog_pkg::ST_FLASH); // see RL7 see RL12 see RL21

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flash_write <= 1'b0;
            flash_addr <= 12'h000;
            flash_wdata <= 8'hFF;
            mem_erase <= 1'b0;
        end
        else
        begin
            flash_write <= timer_start && is_cmd(command, `CMD_WRITE_FLASH);
            mem_erase <= timer_start && is_cmd(command, `CMD_CHIP_ERASE);
            if (timer_start)
            begin
                flash_addr <= {addr.hi, addr.lo};
                flash_wdata <= data_lo;
            end
        end
    end

    // ------------------------------------------------------------
    // fuses and lock bits (one = unprogrammed)
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            serial_prog_enable_fuse <= 1'b0;
            fast_start_fuse <= 1'b1;
        end
        else if (write_pulse && state == nvm_prog_pkg::ST_IDLE && is_cmd(command, `CMD_WRITE_FUSE))
        begin
            // reserved data bits ignored; programmer is expected to hold them high
            serial_prog_enable_fuse <= data_lo[`FUSE_SERIAL_PROG_ENABLE_FUSE_BIT]; // see RL10 see RL12 see RL11
            fast_start_fuse <= data_lo[`FUSE_FAST_START_FUSE_BIT]; // see RL10
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_bit1 <= 1'b1;
            lock_bit2 <= 1'b1;
        end
        else if (state == nvm_prog_pkg::ST_ERASE_LOCK)
        begin
            lock_bit1 <= 1'b1; // see RL14 see RL19
            lock_bit2 <= 1'b1;
        end
        else if (write_pulse && state == nvm_prog_pkg::ST_IDLE && is_cmd(command, `CMD_WRITE_LOCK))
        begin
            // and-ing means a write can only program, never release
            lock_bit1 <= lock_bit1 & data_lo[`LOCK1_BIT]; // see RL13 see RL14
            lock_bit2 <= lock_bit2 & data_lo[`LOCK2_BIT]; // see RL13 see RL14
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prog_data_bus_out <= 8'hFF;
        end
        else if (is_cmd(command, `CMD_READ_FUSE_LOCK) && ctrl.byte_select)
        begin
            prog_data_bus_out <= 8'hFF;
            prog_data_bus_out[`RB_LOCK1_BIT] <= lock_bit1; // see RL15 see RL16
            prog_data_bus_out[`RB_LOCK2_BIT] <= lock_bit2; // see RL16
            prog_data_bus_out[`FUSE_SERIAL_PROG_ENABLE_FUSE_BIT] <= serial_prog_enable_fuse; // see RL16
            prog_data_bus_out[`FUSE_FAST_START_FUSE_BIT] <= fast_start_fuse; // see RL16
        end
        else if (is_cmd(command, `CMD_READ_SIG) && !ctrl.byte_select)
        begin
            case (addr.lo)
                8'h00: prog_data_bus_out <= SIG_BYTE0; // see RL17
                8'h01: prog_data_bus_out <= SIG_BYTE1;
                `SIG_ADDR_MAX: prog_data_bus_out <= SIG_BYTE2;
                default: prog_data_bus_out <= 8'hFF;
            endcase
        end
        else
        begin
            prog_data_bus_out <= 8'hFF;
        end
    end

    assign prog_data_bus_oe = !ctrl.output_enable_n; // see RL18
endmodule // nvm_prog_port
`default_nettype wire

/* File: core/nvm_prog_consts.svh */
// constants for the parallel nonvolatile programming port
//
// Overview of operation
// RL1 - programmer sets action select to 10, byte select low, command on bus
// RL2 - load strobe rising edge latches bus into command register when command selected
// RL3 - command 0001 0000 means write flash
// RL4 - action 00, byte select high: load strobe latches address high byte 0x00-0x0F
// RL5 - action 00, byte select low: load strobe latches address low byte 0x00-0xFF
// RL6 - data loading selected: load strobe latches low data byte
// RL7 - write strobe low pulse, byte select low, starts flash write, busy low
// RL8 - programmer waits for ready before next flash byte
// RL9 - programmer sets action select to 01 before loading data
// RL10 - fuse write: data bit 5 serial enable fuse, bit 0 fast start fuse
// RL11 - programmer drives reserved fuse and lock bits as one
// RL12 - fuse write by write strobe pulse, no ready/busy activity
// RL13 - lock command: data bit 2 programs lock 2, bit 1 lock 1, zero programs
// RL14 - lock bits return unprogrammed only through chip erase; the code also sets both to one on arst_n reset
// RL15 - command 0000 0100, oe low, byte select high: fuse and lock status driven
// RL16 - readback: bit7 lock1, bit6 lock2, bit5 serial enable, bit0 fast start
// RL17 - command 0000 1000, address 0-2, oe low, bs low: signature byte driven
// RL18 - data bus driven only while output enable is low
// RL19 - chip erase clears flash, eeprom, then lock bits; fuses unchanged
// RL20 - latched command, address and data held until overwritten
// RL21 - ready returns high when timed flash write completes
`ifndef NVM_PROG_CONSTS_SVH
`define NVM_PROG_CONSTS_SVH

`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_LOCK 8'h20
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_SIG 8'h08
`define CMD_READ_FUSE_LOCK 8'h04
`define CMD_READ_FLASH 8'h02
`define CMD_READ_EEPROM 8'h03
`define ADDR_HI_MASK 8'h0F
`define FUSE_SERIAL_PROG_ENABLE_FUSE_BIT 5
`define FUSE_FAST_START_FUSE_BIT 0
`define LOCK2_BIT 2
`define LOCK1_BIT 1
`define RB_LOCK1_BIT 7
`define RB_LOCK2_BIT 6
`define FLASH_WRITE_NS 4000
`define CLK_PERIOD_NS 10
`define FLASH_WRITE_CYCLES ((`FLASH_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_STEP_NS 2000
`define ERASE_STEP_CYCLES ((`ERASE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_WORDS 4096
`define SIG_ADDR_MAX 8'h02

`endif

/* File: core/nvm_prog_pkg.sv */
// types for the parallel nonvolatile programming port
package nvm_prog_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_ERASE_MEM, ST_ERASE_LOCK} prog_state_e;

    typedef struct packed {
        logic [1:0] action;
        logic byte_select;
        logic load_strobe;
        logic write_strobe_n;
        logic output_enable_n;
    } prog_ctrl_s;

    typedef struct packed {
        logic [3:0] hi;
        logic [7:0] lo;
    } prog_addr_s;
endpackage

/* File: core/nvm_prog_timer.sv */
// countdown timer used for internally timed operations
`timescale 1ns/1ns
`default_nettype none
module nvm_prog_timer
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [15:0] cycles,
    output logic done
);
    logic [15:0] count;
    logic running;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= 16'h0000;
            running <= 1'b0;
        end
        else if (start)
        begin
            count <= cycles;
            running <= 1'b1;
        end
        else if (running)
        begin
            count <= count - 16'h0001;
            if (count == 16'h0001)
            begin
                running <= 1'b0;
            end
        end
    end

    assign done = running && (count == 16'h0001);
endmodule // nvm_prog_timer
`default_nettype wire

/* File: tb/nvm_prog_port_monitor.sv */
// assertion checker for the programming port
`timescale 1ns/1ns
`default_nettype none
`include "nvm_prog_consts.svh"
module nvm_prog_port_check
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire nvm_prog_pkg::prog_ctrl_s ctrl,
    input wire logic [7:0] prog_data_bus_in,
    input wire logic [7:0] prog_data_bus_out,
    input wire logic prog_data_bus_oe,
    input wire logic ready_busy_n,
    input wire logic flash_write,
    input wire logic mem_erase,
    input wire logic serial_prog_enable_fuse,
    input wire logic fast_start_fuse,
    input wire logic lock_bit1,
    input wire logic lock_bit2,
    input wire logic [7:0] command
);
    localparam int BUSY = `FLASH_WRITE_CYCLES;
    localparam int ERASE = `ERASE_STEP_CYCLES;
    logic ld_q;
    logic wr_q;
    logic ld;
    logic wr;
    logic [7:0] data_lo;
    int busy_cnt;
    int erase_cnt;
    logic idle;
    assign ld = ctrl.load_strobe && !ld_q;
    assign wr = !ctrl.write_strobe_n && wr_q;
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) {ld_q, wr_q} <= 2'h1;
        else {ld_q, wr_q} <= {ctrl.load_strobe, ctrl.write_strobe_n};
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) data_lo <= 8'hFF;
        else if (ld && ctrl.action == `ACT_DATA && !ctrl.byte_select) data_lo <= prog_data_bus_in;
    // counters stand in for long repetitions
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) busy_cnt <= 0;
        else busy_cnt <= ready_busy_n ? 0 : busy_cnt + 1;
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) erase_cnt <= 0;
        else if (mem_erase) erase_cnt <= 1;
        else if (erase_cnt != 0 && erase_cnt < 5000) erase_cnt <= erase_cnt + 1;
    // erase runs with ready high, so idle also needs the erase count
    assign idle = ready_busy_n && !mem_erase && (erase_cnt == 0 || erase_cnt > ERASE);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_oe; prog_data_bus_oe == !ctrl.output_enable_n; endproperty
    a_oe: assert property (p_oe) else $error("bus enable wrong");
    property p_cmd; ld && ctrl.action == `ACT_CMD |=> command == $past(prog_data_bus_in); endproperty
    a_cmd: assert property (p_cmd) else $error("command not latched");
    property p_hold; !(ld && ctrl.action == `ACT_CMD) |=> $stable(command); endproperty
    a_hold: assert property (p_hold) else $error("command changed");
    property p_start;
        wr && idle && command == `CMD_WRITE_FLASH && !ctrl.byte_select |=> !ready_busy_n && flash_write;
    endproperty
    a_start: assert property (p_start) else $error("flash write not started");
    property p_pulse; flash_write |-> $past(wr); endproperty
    a_pulse: assert property (p_pulse) else $error("stray flash write");
    property p_busy; $rose(ready_busy_n) |-> busy_cnt == BUSY; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
    property p_fuse;
        wr && idle && command == `CMD_WRITE_FUSE |=>
            serial_prog_enable_fuse == data_lo[5] && fast_start_fuse == data_lo[0] && ready_busy_n;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse write wrong");
    property p_lock; $rose(lock_bit1) || $rose(lock_bit2) |-> erase_cnt >= ERASE; endproperty
    a_lock: assert property (p_lock) else $error("lock released early");
    property p_read;
        command == `CMD_READ_FUSE_LOCK && ctrl.byte_select && !ctrl.output_enable_n |=>
            prog_data_bus_out == {$past(lock_bit1), $past(lock_bit2), $past(serial_prog_enable_fuse), 4'hF,
            $past(fast_start_fuse)};
    endproperty
    a_read: assert property (p_read) else $error("readback wrong");
    c_flash: cover property (wr && command == `CMD_WRITE_FLASH);
    c_lock: cover property ($rose(lock_bit1));
    c_erase: cover property (mem_erase);
endmodule // nvm_prog_port_check
bind nvm_prog_port nvm_prog_port_check i_chk (.mclk, .arst_n, .ctrl, .prog_data_bus_in, .prog_data_bus_out,
    .prog_data_bus_oe, .ready_busy_n, .flash_write, .mem_erase, .serial_prog_enable_fuse, .fast_start_fuse,
    .lock_bit1, .lock_bit2, .command);
`default_nettype wire

/* File: tb/nvm_prog_programmer.sv */
// programmer model driving the parallel port
`timescale 1ns/1ns
`default_nettype none
module nvm_prog_programmer
(
    input wire logic mclk,
    output var nvm_prog_pkg::prog_ctrl_s ctrl,
    output logic [7:0] bus
);
    initial
    begin
        ctrl = 6'h33;
        bus = 8'hFF;
    end
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
        @(posedge mclk);
        ctrl.action <= act;
        ctrl.byte_select <= bs;
        bus <= d;
        ctrl.load_strobe <= 1'b1;
        @(posedge mclk);
        ctrl.load_strobe <= 1'b0;
        // released bus shows the inverse, never the old byte
        bus <= ~d;
    endtask
    task automatic write;
        @(posedge mclk);
        ctrl.write_strobe_n <= 1'b0;
        @(posedge mclk);
        ctrl.write_strobe_n <= 1'b1;
    endtask
    task automatic read(input logic bs, input logic oe_n);
        @(posedge mclk);
        ctrl.byte_select <= bs;
        ctrl.output_enable_n <= oe_n;
    endtask
endmodule // nvm_prog_programmer
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking testbench for the programming port
`timescale 1ns/1ns
`default_nettype none
`include "nvm_prog_consts.svh"
module testbench;
    logic mclk;
    logic arst_n;
    nvm_prog_pkg::prog_ctrl_s ctrl;
    logic [7:0] pbus;
    wire logic [7:0] bus_in;
    logic [7:0] out;
    logic oe;
    logic rdy;
    logic [11:0] fa;
    logic [7:0] fd;
    logic fw;
    logic er;
    logic sf;
    logic ff;
    logic l1;
    logic l2;
    logic [7:0] cmd;
    int n_fail = 0;
    int cmp_count = 0;
    assign bus_in = oe ? out : pbus;
    always #5 mclk = ~mclk;
    nvm_prog_programmer i_nvm_prog_programmer (.mclk(mclk), .ctrl(ctrl), .bus(pbus));
    nvm_prog_port i_nvm_prog_port (.mclk(mclk), .arst_n(arst_n), .ctrl(ctrl), .prog_data_bus_in(bus_in),
        .prog_data_bus_out(out), .prog_data_bus_oe(oe), .ready_busy_n(rdy), .flash_addr(fa), .flash_wdata(fd),
        .flash_write(fw), .mem_erase(er), .serial_prog_enable_fuse(sf), .fast_start_fuse(ff),
        .lock_bit1(l1), .lock_bit2(l2), .command(cmd));
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait on ready or on lock release
    task automatic wait_hi(input bit lock, output int n);
        n = 0;
        while ((lock ? l1 : rdy) !== 1'b1 && n < 1000)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 1000)
        begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic rd(input logic bs, input logic [7:0] exp);
        i_nvm_prog_programmer.read(bs, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        check(out, exp);
        check(oe, 1);
        i_nvm_prog_programmer.read(bs, 1'b1);
        #1;
        check(oe, 0);
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        check(cmd, 0);
        i_nvm_prog_programmer.load(2'h2, 0, 8'h04);
        rd(1, 8'hDF);
    endtask
    task automatic t_flash;
        int n;
        i_nvm_prog_programmer.load(2'h2, 0, 8'h10);
        i_nvm_prog_programmer.load(2'h0, 1, 8'h0F);
        i_nvm_prog_programmer.load(2'h0, 0, 8'hFF);
        i_nvm_prog_programmer.load(2'h1, 0, 8'hA5);
        i_nvm_prog_programmer.write();
        #1;
        check(fw, 1);
        check(rdy, 0);
        check(fa, 12'hFFF);
        check(fd, 8'hA5);
        // a second strobe while busy must be dropped
        i_nvm_prog_programmer.write();
        #1;
        check(fw, 0);
        wait_hi(0, n);
        check(12'(n + 2), 12'(`FLASH_WRITE_CYCLES));
    endtask
    task automatic t_fuse;
        i_nvm_prog_programmer.load(2'h2, 0, 8'h40);
        i_nvm_prog_programmer.load(2'h1, 0, 8'hFE);
        i_nvm_prog_programmer.write();
        #1;
        check(rdy, 1);
        check({sf, ff}, 2'h2);
        i_nvm_prog_programmer.load(2'h2, 0, 8'h04);
        rd(1, 8'hFE);
    endtask
    task automatic t_lock;
        i_nvm_prog_programmer.load(2'h2, 0, 8'h20);
        i_nvm_prog_programmer.load(2'h1, 0, 8'hF9);
        i_nvm_prog_programmer.write();
        #1;
        check({l1, l2}, 2'h0);
        i_nvm_prog_programmer.load(2'h1, 0, 8'hFF);
        i_nvm_prog_programmer.write();
        #1;
        check({l1, l2}, 2'h0);
        i_nvm_prog_programmer.load(2'h2, 0, 8'h04);
        rd(1, 8'h3E);
    endtask
    task automatic t_sig;
        logic [7:0] sig [3] = '{8'h5A, 8'h11, 8'h22};
        i_nvm_prog_programmer.load(2'h2, 0, 8'h08);
        for (int i = 0; i < 3; i++)
        begin
            i_nvm_prog_programmer.load(2'h0, 0, 8'(i));
            rd(0, sig[i]);
        end
        i_nvm_prog_programmer.load(2'h3, 0, 8'h80);
        #1;
        check(cmd, 8'h08);
    endtask
    task automatic t_erase;
        int n;
        i_nvm_prog_programmer.load(2'h2, 0, 8'h80);
        i_nvm_prog_programmer.write();
        #1;
        check(er, 1);
        wait_hi(1, n);
        check({l1, l2, sf, ff}, 4'hE);
    endtask
    initial
    begin
        mclk = 0;
        arst_n = 0;
        repeat (3) @(posedge mclk);
        arst_n <= 1;
        t_reset();
        t_flash();
        t_fuse();
        t_lock();
        t_sig();
        t_erase();
        complete_run();
    end
endmodule // testbench
`default_nettype wire
